// ---- design/ocp_protect.sv ----
// overcurrent protection state machine with axi4-lite register slave
//
// Functional notes
// RL1 - start detection delay when sense voltage first exceeds threshold; stay normal
// RL2 - detection delay expired with comparator still high enters protection
// RL3 - comparator falling before expiry clears timer; remain in normal operation
// RL4 - entering protection forces discharge FET drive off without software
// RL5 - entering protection enables load test current on load sense pin
// RL6 - load released: stop test current, leave load monitor, stay protected
// RL7 - leaving load monitor starts release timer for the release delay
// RL8 - release expiry with comparator still low returns to normal
// RL9 - on exit discharge FET follows the software control bit
// RL10 - FET bits writable in protection but pins frozen until exit
// RL11 - charge FET output untouched by entry to and exit from protection
// RL12 - detection and release delays equal, 10 ms nominal, one timer
// RL13 - two-bit threshold select in config register drives comparator
// RL14 - load dropping low during release cancels timer, back to monitor
`include "ocp_defines.svh"
module ocp_protect #(
  parameter int unsigned DELAY_CYC = `OCP_DELAY_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog comparators
  input wire logic oc_comparator,
  input wire logic load_released,
  // analog controls and fet pins
  output logic [1:0] oc_threshold_sel,
  output logic load_test_current,
  output logic discharge_fet_drive,
  output logic charge_fet_load_sense_pin,
  // interrupt
  output logic irq
);
  if (DELAY_CYC < 1) begin : g_delay_chk
    $error("DELAY_CYC must be at least one");
  end

  ocp_tmr_if tmr_bus ();

  ocp_delay_timer #(
    .DELAY_CYC(DELAY_CYC)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .t(tmr_bus)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ocp_pkg::ocp_state_t state;
  ocp_pkg::ocp_state_t next_state;
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  logic [1:0] cfg;
  logic [1:0] next_cfg;
  logic [`OCP_IRQ_W-1:0] irq_stat;
  logic [`OCP_IRQ_W-1:0] next_irq_stat;
  logic [`OCP_IRQ_W-1:0] irq_mask;
  logic [`OCP_IRQ_W-1:0] next_irq_mask;
  logic next_dsg_pin;
  logic next_chg_pin;
  logic next_test_cur;
  logic next_irq;
  logic [`OCP_IRQ_W-1:0] ev;
  logic protect;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic aw_held;
  logic next_aw_held;
  logic w_held;
  logic next_w_held;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] s_axi_wstrb_q;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    do_write = aw_held && w_held && !s_axi_bvalid;
    wr_addr = aw_addr;
    wr_data = w_data;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `OCP_RESP_OKAY;
      if (aw_addr != `OCP_ADDR_CTRL && aw_addr != `OCP_ADDR_CFG
          && aw_addr != `OCP_ADDR_IRQ_STAT && aw_addr != `OCP_ADDR_IRQ_MASK
          && aw_addr != `OCP_ADDR_STATUS) begin
        next_bresp = `OCP_RESP_SLVERR;
      end
    end
    // one write in flight; ready drops while a phase is held
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = `OCP_RESP_OKAY;
      unique case (s_axi_araddr)
        `OCP_ADDR_CTRL: next_rdata = {30'h0000_0000, ctrl};
        `OCP_ADDR_CFG: next_rdata = {30'h0000_0000, cfg};
        `OCP_ADDR_STATUS: next_rdata = {27'h000_0000, charge_fet_load_sense_pin,
                                        discharge_fet_drive, load_test_current, state};
        `OCP_ADDR_IRQ_STAT: next_rdata = {29'h0000_0000, irq_stat};
        `OCP_ADDR_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = `OCP_RESP_SLVERR;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // protection fsm
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    ev = '0;
    tmr_bus.clear = 1'b0;
    tmr_bus.run = 1'b0;
    unique case (state)
      ocp_pkg::ocp_normal: begin
        if (!oc_comparator) begin
          tmr_bus.clear = 1'b1; // RL3
        end else begin
          tmr_bus.run = 1'b1; // RL1
          if (tmr_bus.expired) begin
            next_state = ocp_pkg::ocp_load_monitor; // RL2
            tmr_bus.clear = 1'b1;
            ev[`OCP_IRQ_ENTER_BIT] = 1'b1;
          end
        end
      end
      ocp_pkg::ocp_load_monitor: begin
        if (load_released) begin
          next_state = ocp_pkg::ocp_release; // RL6 RL7
          ev[`OCP_IRQ_LOAD_BIT] = 1'b1;
        end
      end
      ocp_pkg::ocp_release: begin
        tmr_bus.run = 1'b1; // RL7 RL12
        if (!load_released) begin
          next_state = ocp_pkg::ocp_load_monitor; // RL14
          tmr_bus.clear = 1'b1; // RL14
        end else if (tmr_bus.expired && !oc_comparator) begin
          next_state = ocp_pkg::ocp_normal; // RL8
          tmr_bus.clear = 1'b1;
          ev[`OCP_IRQ_EXIT_BIT] = 1'b1;
        end
      end
      default: begin
        next_state = ocp_pkg::ocp_normal;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers, pins and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_cfg = cfg;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (do_write) begin
      unique case (wr_addr)
        `OCP_ADDR_CTRL: if (s_axi_wstrb_q[0]) next_ctrl = wr_data[1:0]; // RL10
        `OCP_ADDR_CFG: if (s_axi_wstrb_q[0]) next_cfg = wr_data[1:0]; // RL13
        `OCP_ADDR_IRQ_MASK: if (s_axi_wstrb_q[0]) next_irq_mask = wr_data[2:0];
        `OCP_ADDR_IRQ_STAT: begin
          if (s_axi_wstrb_q[0]) next_irq_stat = irq_stat & ~wr_data[2:0];
        end
        default: begin
        end
      endcase
    end
    // a new event beats a clear in the same cycle
    next_irq_stat = next_irq_stat | ev;
    protect = next_state != ocp_pkg::ocp_normal;
    next_test_cur = next_state == ocp_pkg::ocp_load_monitor; // RL5 RL6
    if (protect) begin
      next_dsg_pin = 1'b0; // RL4 RL10
      next_chg_pin = charge_fet_load_sense_pin; // RL10 RL11
    end else begin
      next_dsg_pin = next_ctrl[`OCP_CTRL_DSG_BIT]; // RL9
      next_chg_pin = next_ctrl[`OCP_CTRL_CHG_BIT]; // RL11
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wstrb_q <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ocp_pkg::ocp_normal;
      ctrl <= `OCP_CTRL_RESET;
      cfg <= `OCP_CFG_RESET;
      irq_stat <= '0;
      irq_mask <= '0;
      discharge_fet_drive <= 1'b1;
      charge_fet_load_sense_pin <= 1'b1;
      load_test_current <= 1'b0;
      oc_threshold_sel <= `OCP_CFG_RESET;
      irq <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      cfg <= next_cfg;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      discharge_fet_drive <= next_dsg_pin;
      charge_fet_load_sense_pin <= next_chg_pin;
      load_test_current <= next_test_cur;
      oc_threshold_sel <= next_cfg; // RL13
      irq <= next_irq;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= (s_axi_arready || s_axi_rvalid) ? next_arready : !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule

// ---- shared/ocp_defines.svh ----
// register offsets, field positions, reset values and timing counts of the overcurrent block
`ifndef OCP_DEFINES_SVH
`define OCP_DEFINES_SVH
`define OCP_ADDR_CTRL 8'h00
`define OCP_ADDR_CFG 8'h04
`define OCP_ADDR_STATUS 8'h08
`define OCP_ADDR_IRQ_STAT 8'h0C
`define OCP_ADDR_IRQ_MASK 8'h10
`define OCP_CTRL_DSG_BIT 0
`define OCP_CTRL_CHG_BIT 1
`define OCP_CTRL_RESET 2'h3
`define OCP_CFG_RESET 2'h0
`define OCP_IRQ_ENTER_BIT 0
`define OCP_IRQ_LOAD_BIT 1
`define OCP_IRQ_EXIT_BIT 2
`define OCP_IRQ_W 3
`define OCP_DELAY_MS 10
`define OCP_CLK_HZ 20000000
`define OCP_DELAY_CYC ((`OCP_DELAY_MS * `OCP_CLK_HZ) / 1000)
`define OCP_RESP_OKAY 2'h0
`define OCP_RESP_SLVERR 2'h2
`endif

// ---- shared/ocp_pkg.sv ----
// types shared by the overcurrent protection block
package ocp_pkg;
  typedef enum logic [1:0] {
    ocp_normal,
    ocp_load_monitor,
    ocp_release
  } ocp_state_t;
endpackage

// ---- shared/ocp_tmr_if.sv ----
// carrier between the protection fsm and its delay timer
interface ocp_tmr_if;
  logic clear;
  logic run;
  logic expired;
  modport ctrl (output clear, output run, input expired);
  modport tmr (input clear, input run, output expired);
endinterface

// ---- design/ocp_delay_timer.sv ----
// shared detection / release delay timer
module ocp_delay_timer #(
  parameter int unsigned DELAY_CYC = 200000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  ocp_tmr_if.tmr t
);
  if (DELAY_CYC < 1) begin : g_delay_chk
    $error("delay must be at least one cycle");
  end

  logic [31:0] count;
  logic [31:0] next_count;
  logic expired;
  logic next_expired;

  // one timer serves both delays, so they cannot differ
  always_comb begin
    next_count = count;
    next_expired = 1'b0;
    if (t.clear || !t.run) begin
      next_count = 32'h0000_0000;
    end else if (count >= DELAY_CYC - 1) begin
      next_expired = 1'b1;
    end else begin
      next_count = count + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 32'h0000_0000;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      expired <= next_expired;
    end
  end

  // clear is left out here: the fsm derives clear from expired, so it would loop
  assign t.expired = expired && t.run;
endmodule

// ---- tb/ocp_protect_chk.sv ----
// assertion checker bound to the overcurrent protection block
module ocp_protect_chk #(
  parameter int unsigned DELAY_CYC = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_bvalid,
  // analog side
  input wire logic oc_comparator,
  input wire logic load_released,
  input wire logic [1:0] oc_threshold_sel,
  input wire logic load_test_current,
  input wire logic discharge_fet_drive,
  input wire logic charge_fet_load_sense_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned oc_cnt;
  int unsigned rel_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // rel_cnt also runs in normal with the fet off; harmless, it only grows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_cnt <= 0;
      rel_cnt <= 0;
    end else begin
      oc_cnt <= (oc_comparator && discharge_fet_drive) ? oc_cnt + 1 : 0;
      if (load_test_current) rel_cnt <= 0;
      else if (load_released && !discharge_fet_drive) rel_cnt <= rel_cnt + 1;
    end
  end
  fet_off_a:
    assert property (load_test_current |-> !discharge_fet_drive) else $error("fet on in monitor");
  entry_delay_a:
    assert property ($rose(load_test_current) && $past(discharge_fet_drive)
      |-> oc_cnt >= DELAY_CYC - 2) else $error("protection entered early");
  entry_bound_a:
    assert property (oc_cnt <= DELAY_CYC + 2) else $error("protection entered late");
  chg_frozen_a:
    assert property (load_test_current |-> $stable(charge_fet_load_sense_pin))
      else $error("charge pin moved");
  mon_exit_a:
    assert property ($fell(load_test_current) |-> $past(load_released)) else $error("early exit");
  mon_stays_a:
    assert property (load_test_current && !load_released |=> load_test_current)
      else $error("monitor left");
  rel_delay_a:
    assert property ($rose(discharge_fet_drive) |-> rel_cnt == 0 || rel_cnt >= DELAY_CYC - 2)
      else $error("release too short");
  rel_cancel_a:
    assert property ($fell(load_released) && rel_cnt != 0 && !discharge_fet_drive
      |-> ##[0:2] load_test_current) else $error("release not cancelled");
  thr_write_a:
    assert property ($changed(oc_threshold_sel) |-> s_axi_bvalid) else $error("threshold moved");
endmodule
bind ocp_protect ocp_protect_chk #(.DELAY_CYC(DELAY_CYC)) ocp_protect_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .oc_comparator(oc_comparator), .load_released(load_released),
  .oc_threshold_sel(oc_threshold_sel), .load_test_current(load_test_current),
  .discharge_fet_drive(discharge_fet_drive),
  .charge_fet_load_sense_pin(charge_fet_load_sense_pin)
);

// ---- tb/ocp_load_model.sv ----
// far side: discharge fet, sense resistor and load
module ocp_load_model (
  // controls from the block
  input wire logic discharge_fet_drive,
  input wire logic [1:0] oc_threshold_sel,
  // load demand from the bench, 0 is no load (load released)
  input wire logic [1:0] load_level,
  // comparators
  output logic oc_comparator,
  output logic load_released
);
  timeunit 1ns;
  timeprecision 1ns;
  // no current flows once the fet is off
  assign oc_comparator = discharge_fet_drive && (load_level > oc_threshold_sel);
  assign load_released = (load_level == 2'h0);
endmodule

// ---- tb/test_overcurrent_protection_fsm.sv ----
// self-checking testbench for the overcurrent protection block
module test_overcurrent_protection_fsm;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned DLY = 8;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, oc_cmp, ld_rel, ltc, fet, chg, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] lvl = 2'h0, bresp, rresp, thr;
  int error_cnt = 0, total_checks = 0, seed = 32'h83E8, m_ctrl = 3, m_mask = 0;
  always #25 aclk = ~aclk;
  ocp_protect #(.DELAY_CYC(DLY)) ocp_protect_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .oc_comparator(oc_cmp), .load_released(ld_rel), .oc_threshold_sel(thr),
    .load_test_current(ltc), .discharge_fet_drive(fet), .charge_fet_load_sense_pin(chg),
    .irq(irq)
  );
  ocp_load_model ocp_load_model_inst (
    .discharge_fet_drive(fet), .oc_threshold_sel(thr), .load_level(lvl),
    .oc_comparator(oc_cmp), .load_released(ld_rel)
  );
  // ----
  // tasks
  // ----
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    // idle edge first, so back-to-back calls never assign bready twice in one step
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
    check("bresp", 32'(bresp), 32'(er));
    if (a == 8'h00) m_ctrl = int'(d[1:0]);
    if (a == 8'h10) m_mask = int'(d[2:0]);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (rvalid !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
    check("rdata", rdata, exp);
    check("rresp", 32'(rresp), 32'(er));
  endtask
  // bounded wait for the test current to reach v; n returns the edges seen
  task automatic wait_ltc(input logic v, output int n);
    n = 0;
    while (ltc !== v && n < 200) begin
      @(posedge aclk);
      n++;
    end
    if (ltc !== v) begin
      error_cnt++;
      complete_run();
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    int n;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, 32'(m_ctrl), 2'h0);
    rd(8'h08, 32'h18, 2'h0);
    rd(8'h14, 32'h0, 2'h2);
    wr(8'h14, 32'h1, 2'h2);
    // a load equal to the threshold never trips
    for (int s = 0; s < 4; s++) begin
      wr(8'h04, 32'(s), 2'h0);
      lvl <= 2'(s);
      repeat (DLY + 4) @(posedge aclk);
      check("thr", 32'(thr), 32'(s));
      check("no_trip", 32'(ltc), 32'h0);
    end
    lvl <= 2'h0;
    wr(8'h04, 32'h0, 2'h0);
    lvl <= 2'h1;
    repeat (DLY - 2) @(posedge aclk);
    lvl <= 2'h0;
    repeat (DLY + 4) @(posedge aclk);
    check("glitch", 32'({ltc, fet}), 32'h1);
    // round 0 keeps the discharge bit and irq unmasked, round 1 clears both
    for (int r = 0; r < 2; r++) begin
      wr(8'h10, 32'(7 * (1 - r)), 2'h0);
      lvl <= 2'(1 + ($unsigned($random(seed)) % 3));
      wait_ltc(1'b1, n);
      check("det_time", 32'(n >= DLY - 2 && n <= DLY + 4), 32'h1);
      check("entry", 32'({fet, irq}), 32'(m_mask != 0));
      rd(8'h08, 32'h15, 2'h0);
      wr(8'h00, 32'(1 - r), 2'h0);
      check("frozen", 32'({fet, chg}), 32'h1);
      lvl <= 2'h0;
      wait_ltc(1'b0, n);
      check("mon_exit", 32'(fet), 32'h0);
      lvl <= 2'h2;
      wait_ltc(1'b1, n);
      check("rearm", 32'(n <= 3), 32'h1);
      lvl <= 2'h0;
      wait_ltc(1'b0, n);
      n = 0;
      while (chg === 1'b1 && n < 200) begin
        @(posedge aclk);
        n++;
      end
      check("rel_time", 32'(n >= DLY - 2 && n <= DLY + 4), 32'h1);
      check("exit_pins", 32'({fet, chg}), 32'((m_ctrl & 1) * 2 + (m_ctrl >> 1)));
      rd(8'h0C, 32'h7, 2'h0);
      wr(8'h0C, 32'h7, 2'h0);
      rd(8'h0C, 32'h0, 2'h0);
      check("irq_clr", 32'(irq), 32'h0);
      wr(8'h00, 32'h3, 2'h0);
    end
    complete_run();
  end
endmodule
